/* File: hw/audio_tx_pkg.sv */
// Purpose: Shared constants for the serial audio word sequencer and its lanes.
// Assumes: APB register bus with 32-bit data, one register per aligned word.
// Notes: Offsets are byte addresses; unused bits of each register read as zero.
package audio_tx_pkg;

  // ==========================================================================
  // Data path sizes
  // ==========================================================================
  localparam int DATA_W = 24;
  localparam int LANES = 3;
  localparam int CNT_W = 6;

  // ==========================================================================
  // Register offsets
  // ==========================================================================
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_DATA_0 = 8'h08;
  localparam logic [7:0] OFS_DATA_1 = 8'h0c;
  localparam logic [7:0] OFS_DATA_2 = 8'h10;

  // ==========================================================================
  // Control register fields
  // ==========================================================================
  localparam int CTL_EN_LSB = 0;
  localparam int CTL_MASTER = 3;
  localparam int CTL_WLEN_LSB = 4;
  localparam int CTL_TX_IRQ_EN = 6;
  localparam logic [6:0] CTL_RESET = 7'h00;

  // ==========================================================================
  // Status register fields
  // ==========================================================================
  localparam int STS_LEFT_EMPTY = 0;
  localparam int STS_RIGHT_EMPTY = 1;
  localparam int STS_EXPECT_RIGHT = 2;
  localparam int STS_BUSY = 3;

  // ==========================================================================
  // Word length codes and bit counts
  // ==========================================================================
  localparam logic [1:0] WLEN_16 = 2'h0;
  localparam logic [1:0] WLEN_24 = 2'h1;
  localparam logic [1:0] WLEN_32 = 2'h2;
  localparam logic [CNT_W-1:0] BITS_16 = 6'h10;
  localparam logic [CNT_W-1:0] BITS_24 = 6'h18;
  localparam logic [CNT_W-1:0] BITS_32 = 6'h20;

  // ==========================================================================
  // Master bit clock timing
  // ==========================================================================
  localparam int CLK_HZ = 25_000_000;
  localparam int BCLK_HALF_NS = 160;
  localparam int BCLK_HALF_CYC = (BCLK_HALF_NS * (CLK_HZ / 1_000_000)) / 1000;

  // Sequencer states.
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_WAIT,
    SEQ_SHIFT
  } seq_state_t;

endpackage

/* File: hw/link_sync.sv */
// Purpose: Two-flop synchroniser with rising edge detection for link pins.
// Assumes: Inputs are asynchronous to pclk.
// Notes: Edge detection reads only the second stage and its delayed copy.
`timescale 1ns/1ns
`default_nettype none
module link_sync #(
  parameter int WIDTH = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise
);

  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;
  logic [WIDTH-1:0] prev_r;

  // Two flops per bit, then one more to find edges.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1_r <= '0;
      stage2_r <= '0;
      prev_r <= '0;
    end else begin
      stage1_r <= async_in;
      stage2_r <= stage1_r;
      prev_r <= stage2_r;
    end
  end

  // Level and edge outputs come from the synchronised stage only.
  assign level = stage2_r;
  assign rise = stage2_r & ~prev_r;

endmodule
`default_nettype wire

/* File: hw/tx_lane.sv */
// Purpose: One transmitter lane: holding register plus shift register.
// Assumes: Load and shift are one-cycle pulses from the sequencer.
// Notes: Data shifts out most significant bit first.
`timescale 1ns/1ns
`default_nettype none
module tx_lane (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr,
  input wire logic [audio_tx_pkg::DATA_W-1:0] wdata,
  input wire logic enable,
  input wire logic load,
  input wire logic shift,
  input wire logic hold,
  input wire logic quiet,
  output logic sd_r
);

  logic [audio_tx_pkg::DATA_W-1:0] data_r;
  logic [audio_tx_pkg::DATA_W-1:0] shift_r;

  // The holding register takes writes at any time, even in reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_r <= '0;
    end else if (wr) begin
      data_r <= wdata;
    end
  end

  // The shifter loads the held word or moves one bit per bit clock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_r <= '0;
    end else if (load) begin
      shift_r <= data_r;
    end else if (shift && !hold) begin
      shift_r <= {shift_r[audio_tx_pkg::DATA_W-2:0], shift_r[0]};
    end
  end

  // Serial output is low while idle, between words or when disabled.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sd_r <= 1'b0;
    end else if (quiet || !enable) begin
      sd_r <= 1'b0;
    end else if (load) begin
      sd_r <= data_r[audio_tx_pkg::DATA_W-1];
    end else if (shift && !hold) begin
      sd_r <= shift_r[audio_tx_pkg::DATA_W-2];
    end
  end

endmodule
`default_nettype wire

/* File: hw/serial_audio_word_sequencer.sv */
// Purpose: Transmit word sequencer of a serial audio unit with APB registers.
// Assumes: Slave mode takes bit clock and word select from pins; master makes them.
// Notes: Word select low marks the left word, high the right word.
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module serial_audio_word_sequencer #(
  parameter int BCLK_HALF = audio_tx_pkg::BCLK_HALF_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic stop_req,
  input wire logic tx_bit_clock_i,
  output logic tx_bit_clock_o,
  output logic tx_bit_clock_oe,
  input wire logic tx_word_select_i,
  output logic tx_word_select_o,
  output logic tx_word_select_oe,
  output logic [2:0] tx_data_o,
  output logic tx_irq,
  output logic rx_status_clear
);

  // Refuse a half period that the 8-bit divider cannot count.
  if (BCLK_HALF < 1 || BCLK_HALF > 255) begin : g_bad_half
    $error("BCLK_HALF must lie between 1 and 255");
  end

  // ==========================================================================
  // Declarations
  // ==========================================================================
  logic [2:0] en_r;
  logic master_r;
  logic [1:0] wlen_r;
  logic tx_irq_enable_r;
  logic left_empty_flag_r;
  logic right_empty_flag_r;
  logic status_seen_r;
  logic [2:0] written_r;
  logic expect_right_r;
  logic [audio_tx_pkg::CNT_W-1:0] count_r;
  audio_tx_pkg::seq_state_t state_r;
  logic [7:0] div_r;
  logic bclk_gen_r;
  logic ws_gen_r;
  logic ws_prev_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic tx_irq_r;
  logic rx_clear_r;
  logic [1:0] sync_level;
  logic [1:0] sync_rise;
  logic in_reset;
  logic tick;
  logic ws_now;
  logic ws_edge;
  logic right_edge;
  logic [audio_tx_pkg::CNT_W-1:0] word_bits;
  logic setup;
  logic access;
  logic wr_ctl;
  logic status_rd;
  logic [2:0] wr_data;
  logic word_end;
  logic expect_right_nxt;
  logic start_word;
  logic load_left;
  logic load_right;
  logic all_written;
  logic clear_ok;
  logic shift_tick;
  logic hold_bits;
  logic quiet;
  logic mapped;

  // ==========================================================================
  // Link pins
  // ==========================================================================

  // Slave pins pass two flops before the sequencer looks at them.
  link_sync #(
    .WIDTH(2)
  ) pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({tx_word_select_i, tx_bit_clock_i}),
    .level(sync_level),
    .rise(sync_rise)
  );

  // Serial logic is held in its own reset while stopped or fully disabled.
  assign in_reset = stop_req || (en_r == 3'h0);

  // Master mode divides pclk into a bit clock; its rising edge is the tick.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 8'h00;
      bclk_gen_r <= 1'b0;
    end else if (in_reset || !master_r) begin
      div_r <= 8'h00;
      bclk_gen_r <= 1'b0;
    end else if (div_r == 8'(BCLK_HALF - 1)) begin
      div_r <= 8'h00;
      bclk_gen_r <= !bclk_gen_r;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  // Tick marks one bit clock period, from the divider or from the pin.
  assign tick = master_r ? (div_r == 8'(BCLK_HALF - 1) && !bclk_gen_r) : sync_rise[0];
  assign ws_now = sync_level[1];
  assign ws_edge = (ws_now != ws_prev_r);
  assign right_edge = ws_now;

  // Word select is remembered at every tick; in individual reset it tracks the pin, so enable sees no stale edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ws_prev_r <= 1'b0;
    end else if (in_reset || tick) begin
      ws_prev_r <= ws_now;
    end
  end

  // ==========================================================================
  // Word sequencer
  // ==========================================================================

  // Word length in bit clocks from the control field.
  always_comb begin
    case (wlen_r)
      audio_tx_pkg::WLEN_16: word_bits = audio_tx_pkg::BITS_16;
      audio_tx_pkg::WLEN_32: word_bits = audio_tx_pkg::BITS_32;
      default: word_bits = audio_tx_pkg::BITS_24;
    endcase
  end

  // A word ends when its bit count meets the programmed length.
  assign word_end = (state_r == audio_tx_pkg::SEQ_SHIFT) && tick && (count_r == word_bits);

  // Side expected by a word starting in this tick.
  assign expect_right_nxt = word_end ? !expect_right_r : expect_right_r;

  // In slave mode the next word starts only on a select edge matching the expected side; master starts it at the next tick.
  always_comb begin
    start_word = 1'b0;
    if (!in_reset && tick) begin
      if (state_r == audio_tx_pkg::SEQ_IDLE && master_r) begin
        start_word = 1'b1;
      end else if (state_r == audio_tx_pkg::SEQ_WAIT || word_end) begin
        if (master_r) begin
          start_word = 1'b1;
        end else begin
          start_word = ws_edge && (right_edge == expect_right_nxt);
        end
      end
    end
  end

  assign load_left = start_word && !expect_right_nxt;
  assign load_right = start_word && expect_right_nxt;

  // State moves idle to wait, or straight to shift when a master word starts at once, shifts a word, then waits again unless the next word starts in the same tick.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= audio_tx_pkg::SEQ_IDLE;
    end else if (in_reset) begin
      state_r <= audio_tx_pkg::SEQ_IDLE;
    end else begin
      case (state_r)
        audio_tx_pkg::SEQ_IDLE: begin
          if (start_word) begin
            state_r <= audio_tx_pkg::SEQ_SHIFT;
          end else begin
            state_r <= audio_tx_pkg::SEQ_WAIT;
          end
        end
        audio_tx_pkg::SEQ_WAIT: begin
          if (start_word) begin
            state_r <= audio_tx_pkg::SEQ_SHIFT;
          end
        end
        audio_tx_pkg::SEQ_SHIFT: begin
          if (word_end && !start_word) begin
            state_r <= audio_tx_pkg::SEQ_WAIT;
          end
        end
        default: state_r <= audio_tx_pkg::SEQ_IDLE;
      endcase
    end
  end

  // Bit count runs only during a word; select edges do not touch it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= '0;
    end else if (in_reset) begin
      count_r <= '0;
    end else if (start_word) begin
      count_r <= 6'h01;
    end else if (state_r == audio_tx_pkg::SEQ_SHIFT && tick && !word_end) begin
      count_r <= count_r + 6'h01;
    end
  end

  // One side bit: forced left in reset, toggled at each finished word.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      expect_right_r <= 1'b0;
    end else if (in_reset) begin
      expect_right_r <= 1'b0;
    end else if (word_end) begin
      expect_right_r <= !expect_right_r;
    end
  end

  // Master word select follows the side of the word that starts.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ws_gen_r <= 1'b0;
    end else if (in_reset || !master_r) begin
      ws_gen_r <= 1'b0;
    end else if (start_word) begin
      ws_gen_r <= expect_right_nxt;
    end
  end

  // Shift enables and output silence for the lanes.
  assign shift_tick = (state_r == audio_tx_pkg::SEQ_SHIFT) && tick && !word_end;
  assign hold_bits = (count_r >= audio_tx_pkg::BITS_24); // last bit repeats on long words
  assign quiet = in_reset || (word_end && !start_word) || (state_r != audio_tx_pkg::SEQ_SHIFT && !start_word);

  // ==========================================================================
  // Transmit lanes
  // ==========================================================================
  genvar lane;
  generate
    for (lane = 0; lane < audio_tx_pkg::LANES; lane++) begin : g_lane
      tx_lane lane_inst (
        .pclk(pclk),
        .presetn(presetn),
        .wr(wr_data[lane]),
        .wdata(pwdata[audio_tx_pkg::DATA_W-1:0]),
        .enable(en_r[lane]),
        .load(start_word),
        .shift(shift_tick),
        .hold(hold_bits),
        .quiet(quiet),
        .sd_r(tx_data_o[lane])
      );
    end
  endgenerate

  // ==========================================================================
  // APB slave
  // ==========================================================================
  assign setup = psel && !penable;
  assign access = psel && penable && pready_r;
  assign mapped = (paddr == audio_tx_pkg::OFS_CONTROL) || (paddr == audio_tx_pkg::OFS_STATUS) ||
                  (paddr == audio_tx_pkg::OFS_DATA_0) || (paddr == audio_tx_pkg::OFS_DATA_1) ||
                  (paddr == audio_tx_pkg::OFS_DATA_2);
  assign wr_ctl = access && pwrite && (paddr == audio_tx_pkg::OFS_CONTROL);
  assign status_rd = access && !pwrite && (paddr == audio_tx_pkg::OFS_STATUS);
  assign wr_data[0] = access && pwrite && (paddr == audio_tx_pkg::OFS_DATA_0);
  assign wr_data[1] = access && pwrite && (paddr == audio_tx_pkg::OFS_DATA_1);
  assign wr_data[2] = access && pwrite && (paddr == audio_tx_pkg::OFS_DATA_2);

  // Every access gets one wait-free access phase; unmapped ones report an error.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup && !mapped;
    end
  end

  // Read data is captured in the setup cycle; data registers read as zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata_r <= 32'h0000_0000;
      if (paddr == audio_tx_pkg::OFS_CONTROL) begin
        prdata_r[6:0] <= {tx_irq_enable_r, wlen_r, master_r, en_r};
      end else if (paddr == audio_tx_pkg::OFS_STATUS) begin
        prdata_r[audio_tx_pkg::STS_LEFT_EMPTY] <= left_empty_flag_r;
        prdata_r[audio_tx_pkg::STS_RIGHT_EMPTY] <= right_empty_flag_r;
        prdata_r[audio_tx_pkg::STS_EXPECT_RIGHT] <= expect_right_r;
        prdata_r[audio_tx_pkg::STS_BUSY] <= (state_r == audio_tx_pkg::SEQ_SHIFT);
      end
    end
  end

  // Control bits change only by software writes, never by stop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {tx_irq_enable_r, wlen_r, master_r, en_r} <= audio_tx_pkg::CTL_RESET;
    end else if (wr_ctl) begin
      en_r <= pwdata[audio_tx_pkg::CTL_EN_LSB +: 3];
      master_r <= pwdata[audio_tx_pkg::CTL_MASTER];
      wlen_r <= pwdata[audio_tx_pkg::CTL_WLEN_LSB +: 2];
      tx_irq_enable_r <= pwdata[audio_tx_pkg::CTL_TX_IRQ_EN];
    end
  end

  // ==========================================================================
  // Empty flags
  // ==========================================================================

  // Writes to every enabled data register are gathered before a clear.
  assign all_written = (((written_r | wr_data) & en_r) == en_r);
  assign clear_ok = (left_empty_flag_r ^ right_empty_flag_r) || status_seen_r;

  // Writes since the last load or completed set, tracked per lane.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      written_r <= 3'h0;
    end else if (in_reset || start_word || (all_written && |wr_data)) begin
      written_r <= 3'h0;
    end else begin
      written_r <= written_r | wr_data;
    end
  end

  // A status read during underrun arms the clear by data writes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_seen_r <= 1'b0;
    end else if (in_reset || (all_written && |wr_data)) begin
      status_seen_r <= 1'b0;
    end else if (status_rd && left_empty_flag_r && right_empty_flag_r) begin
      status_seen_r <= 1'b1;
    end
  end

  // Loading one side sets the other side's flag; a load wins over a clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_empty_flag_r <= 1'b0;
      right_empty_flag_r <= 1'b0;
    end else if (in_reset) begin
      left_empty_flag_r <= 1'b0;
      right_empty_flag_r <= 1'b0;
    end else begin
      if (load_right) begin
        left_empty_flag_r <= 1'b1;
      end else if (all_written && |wr_data && clear_ok) begin
        left_empty_flag_r <= 1'b0;
      end
      if (load_left) begin
        right_empty_flag_r <= 1'b1;
      end else if (all_written && |wr_data && clear_ok) begin
        right_empty_flag_r <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================

  // Interrupt, receive status clear and master pin drive, all registered.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_irq_r <= 1'b0;
      rx_clear_r <= 1'b0;
    end else begin
      tx_irq_r <= tx_irq_enable_r && (left_empty_flag_r || right_empty_flag_r);
      rx_clear_r <= stop_req;
    end
  end

  // Master pins are driven only in master mode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_bit_clock_oe <= 1'b0;
      tx_word_select_oe <= 1'b0;
    end else begin
      tx_bit_clock_oe <= master_r;
      tx_word_select_oe <= master_r;
    end
  end

  assign tx_bit_clock_o = bclk_gen_r;
  assign tx_word_select_o = ws_gen_r;
  assign tx_irq = tx_irq_r;
  assign rx_status_clear = rx_clear_r;
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

endmodule
`default_nettype wire

/* File: verif/sawsq_chk.sv */
// Purpose: Port checker for the word sequencer.
// Assumes: One clock domain, pclk.
// Notes: Bound to every sequencer instance.
`timescale 1ns/1ns
`default_nettype none
module sawsq_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic stop_req,
  input wire logic [2:0] tx_data_o,
  input wire logic tx_irq,
  input wire logic rx_status_clear,
  input wire logic tx_bit_clock_oe,
  input wire logic tx_word_select_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // A bus setup cycle, and a stop state held long enough to settle.
  sequence setup_s; psel && !penable; endsequence
  sequence stop_s; stop_req [*4]; endsequence
  AST_READY: assert property (setup_s |=> pready)
    else $error("pready missing after setup");
  AST_ONE: assert property (pready |=> !pready)
    else $error("pready held too long");
  AST_ERR: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_UNMAP: assert property (setup_s ##0 paddr > 8'h10 |=> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access accepted");
  AST_WO: assert property (setup_s ##0 !pwrite && paddr inside {8'h08, 8'h0c, 8'h10} |=> prdata == 32'h0)
    else $error("data register readable");
  AST_STOPCLR: assert property (rx_status_clear == $past(stop_req))
    else $error("receiver clear not following stop");
  AST_STOPQ: assert property (stop_s |-> tx_data_o == 3'h0)
    else $error("data sent in stop");
  AST_STOPIRQ: assert property (stop_s |-> !tx_irq)
    else $error("interrupt in stop");
  AST_OE: assert property (tx_bit_clock_oe == tx_word_select_oe)
    else $error("pin enables disagree");
endmodule
bind serial_audio_word_sequencer sawsq_chk chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .stop_req, .tx_data_o, .tx_irq, .rx_status_clear, .tx_bit_clock_oe,
  .tx_word_select_oe);
`default_nettype wire

/* File: verif/codec_model.sv */
// Purpose: Slave-side bit clock and word select source that captures data.
// Assumes: 320 ns bit clock; word select low means left.
// Notes: The clock stands low between words.
`timescale 1ns/1ns
`default_nettype none
module codec_model (
  input wire logic [2:0] sd,
  output logic bclk,
  output logic ws
);
  logic [2:0] got [$];
  // Idle: clock low, select on the right side.
  initial begin
    bclk = 1'b0;
    ws = 1'b1;
  end
  // One word of n bits; edge i captures bit i-1, a blip at edge g is mid-word.
  // Both clock edges fall 10 ns off the pclk rising edges, so the synchroniser never races them.
  task automatic word(input logic side, input int n, input int g);
    ws = side;
    for (int i = 0; i <= n; i++) begin
      #150 bclk = 1'b1;
      if (i == g || i == g + 1) ws = ~ws;
      if (i > 0) got.push_back(sd);
      #160 bclk = 1'b0;
      #10;
    end
  endtask
endmodule
`default_nettype wire

/* File: verif/tb_serial_audio_word_sequencer.sv */
// Purpose: Self-checking bench for the word sequencer.
// Assumes: Slave link from codec_model; APB master tasks.
// Notes: Master bit clock shortened with BCLK_HALF of 1.
`timescale 1ns/1ns
`default_nettype none
module tb_serial_audio_word_sequencer;
  logic pclk, presetn, psel, penable, pwrite, stop_req, pready, pslverr, tx_irq;
  logic bclk_o, bclk_oe, ws_o, ws_oe, cbclk, cws;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q, seed;
  logic [2:0] sd;
  logic [23:0] lw [3], rw [3], zw [3];
  int n_mismatch, comparisons;
  wire logic bclk_w = bclk_oe ? bclk_o : cbclk;
  wire logic ws_w = ws_oe ? ws_o : cws;
  serial_audio_word_sequencer #(.BCLK_HALF(1)) dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .stop_req, .tx_bit_clock_i(bclk_w),
    .tx_bit_clock_o(bclk_o), .tx_bit_clock_oe(bclk_oe), .tx_word_select_i(ws_w),
    .tx_word_select_o(ws_o), .tx_word_select_oe(ws_oe), .tx_data_o(sd), .tx_irq, .rx_status_clear());
  codec_model codec (.sd, .bclk(cbclk), .ws(cws));
  // Clock at 25 MHz.
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic results();
    if (n_mismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // One APB transfer; read data lands in q.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic st(input logic [31:0] e);
    apb(1'b0, audio_tx_pkg::OFS_STATUS, 32'h0);
    chk(q, e);
  endtask
  // Random words into all three data registers.
  task automatic fill(output logic [23:0] w [3]);
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      w[i] = seed[23:0];
      apb(1'b1, audio_tx_pkg::OFS_DATA_0 + 8'(4 * i), {8'h00, w[i]});
    end
  endtask
  // Captured bits against the expected words, first bit the top one.
  task automatic cmpw(input logic [23:0] w [3]);
    chk(32'(codec.got.size()), 32'h18);
    for (int i = 23; i >= 0; i--) chk(32'(codec.got.pop_front()), {29'h0, w[2][i], w[1][i], w[0][i]});
  endtask
  // Hang guard.
  initial begin
    repeat (8000) @(posedge pclk);
    n_mismatch++;
    results();
  end
  // Main sequence.
  initial begin
    {psel, penable, pwrite, stop_req, presetn} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    seed = 32'h00000fc1;
    zw = '{default: 24'h0};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    st(32'h0);
    apb(1'b0, 8'h20, 32'h0);
    fill(lw);
    apb(1'b0, audio_tx_pkg::OFS_DATA_0, 32'h0);
    st(32'h0);
    apb(1'b1, audio_tx_pkg::OFS_CONTROL, 32'h57);
    codec.word(1'b1, 24, 99);
    cmpw(zw);
    codec.word(1'b0, 24, 8);
    cmpw(lw);
    st(32'h6);
    chk(32'(tx_irq), 32'h1);
    fill(rw);
    st(32'h4);
    codec.word(1'b1, 24, 99);
    cmpw(rw);
    st(32'h1);
    codec.word(1'b0, 24, 99);
    cmpw(rw);
    fill(lw);
    st(32'h7);
    fill(lw);
    st(32'h4);
    apb(1'b1, audio_tx_pkg::OFS_CONTROL, 32'h50);
    st(32'h0);
    fill(lw);
    apb(1'b1, audio_tx_pkg::OFS_CONTROL, 32'h57);
    stop_req <= 1'b1;
    apb(1'b0, audio_tx_pkg::OFS_CONTROL, 32'h0);
    chk(q, 32'h57);
    st(32'h0);
    stop_req <= 1'b0;
    apb(1'b1, audio_tx_pkg::OFS_CONTROL, 32'h1f);
    repeat (20) @(posedge pclk);
    apb(1'b0, audio_tx_pkg::OFS_STATUS, 32'h0);
    chk(q & 32'h2, 32'h2);
    chk(32'(tx_irq), 32'h0);
    chk(32'(bclk_oe), 32'h1);
    chk(32'(ws_o), 32'h0);
    apb(1'b1, audio_tx_pkg::OFS_CONTROL, 32'h0);
    stop_req <= 1'b1;
    st(32'h0);
    results();
  end
endmodule
`default_nettype wire
